/* File: cfd_clock_ctrl.sv */
// clock source select with failure detection, recovery and apb registers
`timescale 1ns/1ns
`default_nettype none
module cfd_clock_ctrl
    import cfd_pkg::*;
#(
    parameter int SYS_FAIL_CYCLES = CFD_SYS_FAIL_CYCLES, // primary gap limit
    parameter int WDT_FAIL_CYCLES = CFD_WDT_FAIL_CYCLES  // watchdog gap limit
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // oscillator clocks seen as pins, asynchronous
    input  wire logic        ipo_clk_pin,
    input  wire logic        xtal_clk_pin,
    input  wire logic        wdt_clk_pin,
    input  wire logic        ext_clk_pin,
    // oscillator enables
    output logic             ipo_en,
    output logic             xtal_en,
    output logic             wdtosc_en,
    // one-hot clock gates, index by source code
    output logic [3:0]       clk_gate,
    // events
    output logic             nmi,
    output logic             irq
);
    // ======================================================================
    // declarations

    // pin synchroniser, stage one read only by stage two
    logic [3:0]   sync1_q;                   // first stage
    logic [3:0]   sync2_q;                   // second stage, safe to read

    // registers
    cfd_ctrl_type ctrl_q, ctrl_d;            // oscillator_control_reg
    cfd_evt_type  stat_q, stat_d;            // sticky events
    cfd_evt_type  mask_q, mask_d;            // interrupt mask
    logic         recov_q, recov_d;          // forced onto watchdog osc
    logic         wfail_q, wfail_d;          // watchdog osc failed once

    // bus answer
    logic         pready_q, pready_d;
    logic [31:0]  prdata_q, prdata_d;
    logic         pslverr_q, pslverr_d;
    logic         irq_q, irq_d;
    logic         nmi_q, nmi_d;

    // switch sequencer
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,                      // one gate on
        ST_GAP = 2'b10                       // all gates off
    } cfd_sw_type;
    cfd_sw_type   sw_q, sw_d;
    logic [1:0]   act_q, act_d;              // source now driving
    logic [2:0]   gap_q, gap_d;              // gap countdown
    logic [3:0]   gate_q, gate_d;            // gate outputs

    // detector wiring
    logic         sys_fail;                  // primary failure pulse
    logic         wdt_fail;                  // watchdog failure pulse
    logic         sys_watch_en;
    logic         sys_sample;
    logic [1:0]   target;                    // source wanted now
    logic         wr_ok;                     // write takes effect now
    logic         rd_first;                  // first access cycle

    // refuse limits below twice the gap length
    if (SYS_FAIL_CYCLES < 8 || WDT_FAIL_CYCLES < 8) begin : g_chk
        $error("cfd_clock_ctrl: failure limits too small");
    end

    // ======================================================================
    // helpers

    // decode an offset into a read value
    function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                           input cfd_ctrl_type c,
                                           input cfd_evt_type s,
                                           input cfd_evt_type m,
                                           input logic [1:0] act,
                                           input logic rc,
                                           input logic wf);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            CFD_OFS_CTRL:   v = {24'h00_0000, c};
            CFD_OFS_STATUS: v = {30'h0000_0000, s};
            CFD_OFS_MASK:   v = {30'h0000_0000, m};
            CFD_OFS_STATE:  v = {28'h000_0000, wf, rc, act};
            default:        v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // is the offset one of ours
    function automatic logic hit(input logic [7:0] a);
        return (a == CFD_OFS_CTRL) || (a == CFD_OFS_STATUS) ||
               (a == CFD_OFS_MASK) || (a == CFD_OFS_STATE);
    endfunction

    // ======================================================================
    // synchroniser for the four oscillator pins
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {ext_clk_pin, wdt_clk_pin, xtal_clk_pin, ipo_clk_pin};
            sync2_q <= sync1_q;
        end
    end

    // ======================================================================
    // failure detectors

    // primary watch sees the gated active clock, so a switch with the
    // detector left on can look like a dead clock during the gap
    // no suppression while switching
    assign sys_watch_en = ctrl_q.sysosc_fail_detect_en && !wfail_q &&
                          !recov_q && (act_q != CFD_SRC_WDT);
    assign sys_sample   = sync2_q[act_q] & gate_q[act_q];

    cfd_edge_watch #(
        .LIMIT  (SYS_FAIL_CYCLES)
    ) u_sys_watch (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .en     (sys_watch_en),
        .sample (sys_sample),
        .fail_q (sys_fail)
    );

    cfd_edge_watch #(
        .LIMIT  (WDT_FAIL_CYCLES)
    ) u_wdt_watch (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .en     (ctrl_q.wdtosc_fail_detect_en),
        .sample (sync2_q[CFD_SRC_WDT]),
        .fail_q (wdt_fail)
    );

    // ======================================================================
    // apb timing: access phase lasts two cycles, write at the pready edge
    assign rd_first = psel && penable && !pready_q;
    assign wr_ok    = psel && penable && pready_q && pwrite && hit(paddr);

    // ======================================================================
    // register next values
    always_comb begin
        ctrl_d  = ctrl_q;
        stat_d  = stat_q;
        mask_d  = mask_q;
        recov_d = recov_q;
        wfail_d = wfail_q;
        // software writes
        if (wr_ok) begin
            case (paddr)
                CFD_OFS_CTRL: begin
                    ctrl_d       = cfd_ctrl_type'(pwdata[7:0]);
                    ctrl_d.spare = 1'b0;
                    // enables accepted with any select
                    // a control write hands control back to software, unless a primary failure with wdtosc_en set lands in the same cycle
                    recov_d      = 1'b0;
                end
                CFD_OFS_STATUS: begin
                    // write one to clear
                    stat_d = stat_q & ~cfd_evt_type'(pwdata[1:0]);
                end
                CFD_OFS_MASK: begin
                    mask_d = cfd_evt_type'(pwdata[1:0]);
                end
                default: begin
                    // state register is read only
                end
            endcase
        end
        // primary failure event, set beats clear
        if (sys_fail) begin
            stat_d.sys_fail = 1'b1;
            if (ctrl_q.wdtosc_en) begin
                recov_d = 1'b1;
            end
        end
        if (wdt_fail) begin
            stat_d.wdt_fail = 1'b1;
            wfail_d         = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrl_q  <= cfd_ctrl_type'(CFD_CTRL_RST);
            stat_q  <= cfd_evt_type'(CFD_EVT_RST);
            mask_q  <= cfd_evt_type'(CFD_EVT_RST);
            recov_q <= 1'b0;
            wfail_q <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            recov_q <= recov_d;
            wfail_q <= wfail_d;
        end
    end

    // ======================================================================
    // bus answer and event outputs, next values
    always_comb begin
        pready_d  = rd_first;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (rd_first) begin
            // read data fixed on the first access cycle
            prdata_d  = pwrite ? 32'h0000_0000 :
                        rd_mux(paddr, ctrl_q, stat_q, mask_q, act_q,
                               recov_q, wfail_q);
            // unmapped offsets answer with an error
            pslverr_d = !hit(paddr);
        end
        // nmi ignores the mask; irq is the masked copy
        nmi_d = |stat_d;
        irq_d = |(stat_d & mask_d);
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            nmi_q     <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            nmi_q     <= nmi_d;
            irq_q     <= irq_d;
        end
    end

    // ======================================================================
    // switch sequencer
    // recovery overrides the select
    assign target = recov_q ? CFD_SRC_WDT : ctrl_q.clock_source_select;

    // gates drop together, stay low for a gap, then the new one rises;
    // the cells behind clk_gate retime on their own clock low phase
    always_comb begin
        sw_d   = sw_q;
        act_d  = act_q;
        gap_d  = gap_q;
        gate_d = gate_q;
        case (sw_q)
            ST_RUN: begin
                if (target != act_q) begin
                    sw_d   = ST_GAP;
                    gate_d = 4'h0;
                    gap_d  = CFD_GAP_CYCLES;
                end
            end
            ST_GAP: begin
                if (gap_q > 3'h1) begin
                    gap_d = gap_q - 3'h1;
                end else begin
                    // new target taken at the end of the gap
                    sw_d   = ST_RUN;
                    act_d  = target;
                    gate_d = 4'h1 << target;
                end
            end
            default: begin
                sw_d   = ST_RUN;
                gate_d = 4'h0;
            end
        endcase
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sw_q   <= ST_RUN;
            act_q  <= CFD_SRC_IPO;
            gap_q  <= 3'h0;
            gate_q <= 4'h1;
        end else begin
            sw_q   <= sw_d;
            act_q  <= act_d;
            gap_q  <= gap_d;
            gate_q <= gate_d;
        end
    end

    // ======================================================================
    // outputs, all from flip-flops
    assign pready    = pready_q;
    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q;
    assign ipo_en    = ctrl_q.ipo_en;
    assign xtal_en   = ctrl_q.xtal_en;
    assign wdtosc_en = ctrl_q.wdtosc_en;
    assign clk_gate  = gate_q;
    assign nmi       = nmi_q;
    assign irq       = irq_q;

endmodule
`default_nettype wire

/* File: cfd_clock_ctrl_props.sv */
// port-level assertions for the clock failure block
`timescale 1ns/1ns
`default_nettype none
module cfd_clock_ctrl_props
    import cfd_pkg::*;
#(
    parameter int SYS_FAIL_CYCLES = 16, // primary gap limit
    parameter int WDT_FAIL_CYCLES = 12  // watchdog gap limit
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // oscillator pins
    input wire logic        ipo_clk_pin,
    input wire logic        xtal_clk_pin,
    input wire logic        wdt_clk_pin,
    input wire logic        ext_clk_pin,
    // enables, gates, events
    input wire logic        ipo_en,
    input wire logic        xtal_en,
    input wire logic        wdtosc_en,
    input wire logic [3:0]  clk_gate,
    input wire logic        nmi,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // ======================================================================
    // apb handshake: exactly one wait state, one-cycle ready
    property p_one_wait;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("ready not after one wait state");
    property p_ready_pulse;
        pready |-> $past(psel && penable) ##1 !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready without access or too long");
    property p_err_map;
        pready && paddr > CFD_OFS_STATE |-> pslverr;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("unmapped offset not refused");
    property p_ok_map;
        pready && paddr[1:0] == 2'h0 && paddr <= CFD_OFS_STATE |-> !pslverr;
    endproperty
    a_ok_map: assert property (p_ok_map)
        else $error("mapped offset refused");

    // ======================================================================
    // clock switch: all gates off four cycles, then one gate
    property p_gap;
        $fell(|clk_gate) |-> (clk_gate == 4'h0)[*4] ##1 $onehot(clk_gate);
    endproperty
    a_gap: assert property (p_gap)
        else $error("switch gap wrong");
    property p_onehot;
        $onehot0(clk_gate);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("two clock gates open");

    // ======================================================================
    // events and enables
    property p_nmi_clear;
        $fell(nmi) |-> $past(pready && pwrite && paddr == CFD_OFS_STATUS, 1);
    endproperty
    a_nmi_clear: assert property (p_nmi_clear)
        else $error("event dropped without clear");
    property p_irq_nmi;
        irq |-> nmi;
    endproperty
    a_irq_nmi: assert property (p_irq_nmi)
        else $error("irq without pending event");
    property p_en_by_write;
        $changed({ipo_en, xtal_en, wdtosc_en}) |->
            $past(pready && pwrite && paddr == CFD_OFS_CTRL, 1) ||
            $past(pready && pwrite && paddr == CFD_OFS_CTRL, 2);
    endproperty
    a_en_by_write: assert property (p_en_by_write)
        else $error("oscillator enable moved by itself");

    // main scenarios reached
    c_switch: cover property ($fell(|clk_gate));
    c_event: cover property ($rose(nmi));
    c_refuse: cover property (pready && pslverr);
endmodule

bind cfd_clock_ctrl cfd_clock_ctrl_props #(
    .SYS_FAIL_CYCLES(SYS_FAIL_CYCLES),
    .WDT_FAIL_CYCLES(WDT_FAIL_CYCLES)
) u_props (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ipo_clk_pin(ipo_clk_pin),
    .xtal_clk_pin(xtal_clk_pin), .wdt_clk_pin(wdt_clk_pin),
    .ext_clk_pin(ext_clk_pin), .ipo_en(ipo_en), .xtal_en(xtal_en),
    .wdtosc_en(wdtosc_en), .clk_gate(clk_gate), .nmi(nmi), .irq(irq)
);
`default_nettype wire

/* File: cfd_edge_watch.sv */
// edge watchdog: counts mclk cycles between edges of a sampled clock
`timescale 1ns/1ns
`default_nettype none
module cfd_edge_watch #(
    parameter int LIMIT = 8004               // cycles without edge = failure
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // watched signal, already synchronised
    input  wire logic en,
    input  wire logic sample,
    // one-cycle failure pulse
    output logic      fail_q
);
    localparam int W = $clog2(LIMIT + 1);

    // refuse limits the counter cannot serve
    if (LIMIT < 2) begin : g_chk
        $error("cfd_edge_watch: LIMIT must be at least 2");
    end

    logic         prev_q;                    // last sample, for edge detect
    logic         prev_d;
    logic [W-1:0] cnt_q;                     // cycles since last edge
    logic [W-1:0] cnt_d;
    logic         fail_d;
    logic         done_q;                    // fired, waits for an edge
    logic         done_d;

    // next-state: restart on edge, fire once at the limit
    always_comb begin
        prev_d = sample;
        cnt_d  = cnt_q;
        fail_d = 1'b0;
        done_d = done_q;
        if (!en) begin
            // disabled detector holds at zero
            cnt_d  = '0;
            done_d = 1'b0;
        end else if (sample != prev_q) begin
            cnt_d  = '0;
            done_d = 1'b0;
        end else if (!done_q) begin
            if (cnt_q == W'(LIMIT - 1)) begin
                fail_d = 1'b1;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + W'(1);
            end
        end
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prev_q <= 1'b0;
            cnt_q  <= '0;
            fail_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            cnt_q  <= cnt_d;
            fail_q <= fail_d;
            done_q <= done_d;
        end
    end
endmodule
`default_nettype wire

/* File: cfd_pkg.sv */
// constants and types for the clock failure block
// ===========================================================================
// ===========================================================================
package cfd_pkg;

    // ======================================================================
    // register offsets (byte addresses on the apb bus)
    localparam logic [7:0] CFD_OFS_CTRL   = 8'h00; // oscillator_control_reg
    localparam logic [7:0] CFD_OFS_STATUS = 8'h04; // sticky events, w1c
    localparam logic [7:0] CFD_OFS_MASK   = 8'h08; // interrupt mask
    localparam logic [7:0] CFD_OFS_STATE  = 8'h0C; // live state, read only

    // ======================================================================
    // clock source codes for clock_source_select
    localparam logic [1:0] CFD_SRC_IPO  = 2'h0; // internal_precision_osc
    localparam logic [1:0] CFD_SRC_XTAL = 2'h1; // crystal oscillator
    localparam logic [1:0] CFD_SRC_WDT  = 2'h2; // watchdog oscillator
    localparam logic [1:0] CFD_SRC_EXT  = 2'h3; // external clock pin

    // ======================================================================
    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       ipo_en;                 // internal_precision_osc on
        logic       xtal_en;                // crystal oscillator on
        logic       wdtosc_en;              // watchdog oscillator on
        logic       spare;                  // reads zero
        logic       sysosc_fail_detect_en;  // primary detector on
        logic       wdtosc_fail_detect_en;  // watchdog detector on
        logic [1:0] clock_source_select;    // wanted source
    } cfd_ctrl_type;

    // event layout shared by status and mask
    typedef struct packed {
        logic wdt_fail;                     // watchdog oscillator died
        logic sys_fail;                     // primary oscillator died
    } cfd_evt_type;

    // values after reset
    localparam logic [7:0] CFD_CTRL_RST = 8'hA0; // ipo and wdt osc on
    localparam logic [1:0] CFD_EVT_RST  = 2'h0;

    // ======================================================================
    // timing
    localparam int CFD_CLK_PERIOD_NS   = 50;      // mclk at 20 MHz
    localparam int CFD_SYS_FAIL_KHZ    = 1;       // primary floor frequency
    localparam int CFD_SYS_FAIL_NS     = 1000000 / CFD_SYS_FAIL_KHZ;
    // longest tolerated gap between edges, rounded down
    localparam int CFD_SYS_FAIL_CYCLES = CFD_SYS_FAIL_NS / CFD_CLK_PERIOD_NS;
    localparam int CFD_WDT_FAIL_CYCLES = 8004;    // mclk cycles, no wdt edge
    localparam logic [2:0] CFD_GAP_CYCLES = 3'h4; // all gates off on switch

endpackage

/* File: test_clock_failure_detect_recovery.sv */
// self-checking bench for the clock failure block
`timescale 1ns/1ns
`default_nettype none
module test_clock_failure_detect_recovery
    import cfd_pkg::*;
;
    logic        mclk = 1'b0;      // 20 MHz system clock
    logic        rst_b = 1'b0;     // synchronous reset
    logic        psel = 1'b0;      // apb request
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [3:0]  pins_q = 4'h0;    // oscillator pins by source code
    logic [3:0]  run_q = 4'hF;     // which oscillators are alive
    logic        ipo_en;
    logic        xtal_en;
    logic        wdtosc_en;
    logic [3:0]  clk_gate;
    logic        nmi;
    logic        irq;
    int          bad_count = 0;
    int          n_checks = 0;

    // small gap limits keep the run short
    cfd_clock_ctrl #(.SYS_FAIL_CYCLES(16), .WDT_FAIL_CYCLES(12)) uut (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .ipo_clk_pin(pins_q[0]),
        .xtal_clk_pin(pins_q[1]), .wdt_clk_pin(pins_q[2]),
        .ext_clk_pin(pins_q[3]), .ipo_en(ipo_en), .xtal_en(xtal_en),
        .wdtosc_en(wdtosc_en), .clk_gate(clk_gate), .nmi(nmi), .irq(irq)
    );

    // ======================================================================
    // clock, and live oscillators toggling each mclk rising edge; a dead one holds
    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        pins_q <= pins_q ^ run_q;
    end

    // ======================================================================
    // apb master: holds the request until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [32:0] res);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        // ends on pready; if it never comes, only the hang guard ends this wait
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        res = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // register result compare: error flag and data together
    task automatic chk_reg(input logic [7:0] a, input logic [32:0] exp,
                           input logic [32:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch reg %h expected %h seen %h", a, exp, got);
        end
    endtask

    // port compare: {ipo,xtal,wdtosc,nmi,irq,gate}
    task automatic chk_out(input logic [8:0] exp);
        logic [8:0] got;
        @(posedge mclk);
        got = {ipo_en, xtal_en, wdtosc_en, nmi, irq, clk_gate};
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch ports expected %h seen %h", exp, got);
        end
    endtask

    // read with expected data, or write checking only the error flag; unmapped offsets must be refused
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk_reg(a, {a > CFD_OFS_STATE, exp}, r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
        chk_reg(a, {a > CFD_OFS_STATE, 32'h0}, {r[32], 32'h0});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        stop_test();
    end

    // ======================================================================
    // test sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        chk_out(9'h141);
        rd(CFD_OFS_CTRL, 32'hA0);
        rd(CFD_OFS_STATUS, 32'h0);
        rd(CFD_OFS_MASK, 32'h0);
        wr(CFD_OFS_STATE, 32'hFF);
        rd(CFD_OFS_STATE, 32'h0);
        rd(8'h10, 32'h0);
        wr(8'h10, 32'hFF);
        $display("test reset and map done");
        // detectors off, move to crystal; precision osc stays on
        wr(CFD_OFS_CTRL, 32'hE1);
        idle(10);
        chk_out(9'h1C2);
        rd(CFD_OFS_STATE, 32'h01);
        $display("test switch done");
        // crystal dies with primary detection on: recovery to watchdog osc
        wr(CFD_OFS_CTRL, 32'hE9);
        run_q <= 4'hD;
        idle(40);
        chk_out(9'h1E4);
        rd(CFD_OFS_STATUS, 32'h01);
        rd(CFD_OFS_STATE, 32'h06);
        wr(CFD_OFS_MASK, 32'h01);
        rd(CFD_OFS_MASK, 32'h01);
        idle(3);
        chk_out(9'h1F4);
        wr(CFD_OFS_STATUS, 32'h01);
        idle(3);
        chk_out(9'h1C4);
        rd(CFD_OFS_STATUS, 32'h0);
        $display("test recovery done");
        // watchdog osc off: failure flagged but no switch
        run_q <= 4'hF;
        wr(CFD_OFS_CTRL, 32'h80);
        wr(CFD_OFS_CTRL, 32'h88);
        idle(10);
        chk_out(9'h101);
        run_q <= 4'hC;
        idle(40);
        chk_out(9'h131);
        rd(CFD_OFS_STATE, 32'h0);
        run_q <= 4'hF;
        idle(5);
        wr(CFD_OFS_STATUS, 32'h01);
        idle(3);
        chk_out(9'h101);
        $display("test no recovery done");
        // external clock: primary detection kept off
        wr(CFD_OFS_CTRL, 32'hA0);
        idle(10);
        wr(CFD_OFS_CTRL, 32'hA3);
        idle(10);
        chk_out(9'h148);
        rd(CFD_OFS_STATE, 32'h03);
        wr(CFD_OFS_CTRL, 32'hA0);
        idle(10);
        $display("test external clock done");
        // watchdog detection: live edges keep it quiet, then it dies
        wr(CFD_OFS_CTRL, 32'hA4);
        idle(30);
        rd(CFD_OFS_STATUS, 32'h0);
        wr(CFD_OFS_CTRL, 32'hAC);
        run_q <= 4'hB;
        idle(30);
        chk_out(9'h161);
        rd(CFD_OFS_STATE, 32'h08);
        rd(CFD_OFS_STATUS, 32'h02);
        run_q <= 4'hA;
        idle(40);
        rd(CFD_OFS_STATUS, 32'h02);
        wr(CFD_OFS_MASK, 32'h02);
        idle(3);
        chk_out(9'h171);
        $display("test watchdog failure done");
        stop_test();
    end
endmodule
`default_nettype wire
